/* File: hdl/rcc_pkg.sv */
// Constants, encodings and register layout of the retry and card control register slice.
`default_nettype none
package rcc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_ROUTE = 8'h8C;
  localparam logic [7:0] IDX_AUX = 8'h8D;
  localparam logic [7:0] IDX_RETRY = 8'h90;
  localparam logic [7:0] IDX_CARD = 8'h91;
  localparam logic [7:0] IDX_ISTAT = 8'h94;
  localparam logic [7:0] IDX_IMASK = 8'h95;

  localparam int RS_HOST_EN = 7;
  localparam int RS_CARD_EN = 6;
  localparam int RS_CBB_EXP = 5;
  localparam int RS_CBA_EXP = 3;
  localparam int RS_HOST_EXP = 1;
  localparam logic [7:0] RETRY_RESET = 8'hC0;
  localparam logic [7:0] RETRY_RD_MASK = 8'hEA;

  localparam int CC_RING_EN = 7;
  localparam int CC_VIDEO = 6;
  localparam int CC_RSVD5 = 5;
  localparam int CC_RSVD4 = 4;
  localparam int CC_RSVD3 = 3;
  localparam int CC_AUDIO_MUX = 2;
  localparam int CC_SPK_EN = 1;
  localparam int CC_FUNC_IRQ = 0;
  localparam logic [7:0] CARD_RESET = 8'h00;

  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  localparam int RT_T0_LSB = 0;
  localparam int RT_T1_LSB = 4;
  localparam int RT_T2_LSB = 8;
  localparam int RT_FIELD_W = 4;

  localparam int AUX_GPO_LSB = 0;
  localparam int AUX_GPO_W = 3;
  localparam int AUX_RING_MUX = 4;
  localparam int AUX_GPIN_LSB = 8;
  localparam logic [7:0] AUX_RESET = 8'h00;

  localparam int INT_W = 4;
  localparam int IS_HOST = 0;
  localparam int IS_CBA = 1;
  localparam int IS_CBB = 2;
  localparam int IS_FUNC = 3;

  localparam int unsigned RETRY_LIMIT = 32768;

  typedef enum logic [3:0] {
    FN_GP_IN = 4'h0,
    FN_GP_OUT = 4'h1,
    FN_ALT2 = 4'h2,
    FN_IRQ3 = 4'h3,
    FN_IRQ4 = 4'h4,
    FN_IRQ5 = 4'h5,
    FN_VID_STAT = 4'h6,
    FN_VID_SEL = 4'h7,
    FN_AUDIO = 4'h8,
    FN_IRQ9 = 4'h9,
    FN_IRQ10 = 4'hA,
    FN_IRQ11 = 4'hB,
    FN_LED = 4'hC,
    FN_IRQ13 = 4'hD,
    FN_EVENT = 4'hE,
    FN_IRQ15 = 4'hF
  } rcc_func_e;

  localparam logic [3:0] T2_RING_CODE = 4'hC;
  localparam logic [3:0] T2_EVENT_CODE = 4'hE;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_WAIT = 1'b1
  } rcc_tmr_e;
endpackage : rcc_pkg
`default_nettype wire

/* File: hdl/rcc_retry_timer.sv */
// Retry timeout counter for one target: flags a master that does not come back in time.
`default_nettype none
module rcc_retry_timer #(
  parameter int unsigned LIMIT = rcc_pkg::RETRY_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic retry_start_i,
  input wire logic master_back_i,
  output logic expired_o
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  typedef struct packed {
    rcc_pkg::rcc_tmr_e state;
    logic [CW-1:0] cnt;
    logic expired;
  } rcc_tmr_s;

  rcc_tmr_s st_q;
  rcc_tmr_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.expired = 1'b0;
    unique case (st_q.state)
      rcc_pkg::TMR_IDLE: begin
        if (retry_start_i && enable_i) begin
          st_d.state = rcc_pkg::TMR_WAIT;
          st_d.cnt = '0;
        end
      end
      rcc_pkg::TMR_WAIT: begin
        // Disabling drops the pending wait, so re-enabling never fires a stale timeout.
        if (!enable_i) begin
          st_d.state = rcc_pkg::TMR_IDLE;
        end else if (retry_start_i) begin
          st_d.cnt = '0;
        end else if (master_back_i) begin
          st_d.state = rcc_pkg::TMR_IDLE;
        end else if (st_q.cnt == LAST) begin
          st_d.expired = 1'b1;
          st_d.state = rcc_pkg::TMR_IDLE;
        end else begin
          st_d.cnt = CW'(st_q.cnt + 1'b1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: rcc_pkg::TMR_IDLE, cnt: '0, expired: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign expired_o = st_q.expired;

  a_count_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enable_i |=> !expired_o) else $error("retry timeout fired while disabled");

  a_expire_at_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    expired_o |-> ($past(st_q.cnt) == LAST && $past(st_q.state) == rcc_pkg::TMR_WAIT))
    else $error("retry timeout fired before the full count");
endmodule : rcc_retry_timer
`default_nettype wire

/* File: hdl/rcc_regs.sv */
// Retry status, card control and terminal routing registers behind an AHB-Lite slave.
`default_nettype none
module rcc_regs #(
  parameter int unsigned RETRY_LIMIT = rcc_pkg::RETRY_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  input wire logic host_retry_start_i,
  input wire logic host_master_back_i,
  input wire logic card_a_retry_start_i,
  input wire logic card_a_master_back_i,
  input wire logic card_b_retry_start_i,
  input wire logic card_b_master_back_i,
  input wire logic card_func_irq_i,
  input wire logic [15:0] irq_lines_i,
  input wire logic inta_n_i,
  input wire logic serial_data_i,
  input wire logic video_status_i,
  input wire logic video_select_i,
  input wire logic audio_pwm_i,
  input wire logic card_audio_i,
  input wire logic socket_activity_led_i,
  input wire logic general_event_i,
  input wire logic ring_indicate_n_i,
  input wire logic pme_n_i,
  input wire logic card_speaker_i,
  input wire logic multi_terminal_0_i,
  output logic multi_terminal_0_o,
  output logic multi_terminal_0_oe_n_o,
  input wire logic multi_terminal_1_i,
  output logic multi_terminal_1_o,
  output logic multi_terminal_1_oe_n_o,
  input wire logic multi_terminal_2_i,
  output logic multi_terminal_2_o,
  output logic multi_terminal_2_oe_n_o,
  output logic ring_pme_n_o,
  output logic speaker_out_terminal_o,
  output logic speaker_out_terminal_oe_n_o,
  output logic video_hiz_o
);
  typedef struct packed {
    logic [31:0] route;
    logic [7:0] aux;
    logic host_en;
    logic card_en;
    logic host_exp;
    logic cba_exp;
    logic cbb_exp;
    logic ring_en;
    logic video_en;
    logic rsvd5;
    logic audio_mux;
    logic spk_en;
    logic func_flag;
    logic [rcc_pkg::INT_W-1:0] istat;
    logic [rcc_pkg::INT_W-1:0] imask;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic irq;
    logic [2:0] term_val;
    logic [2:0] term_oe_n;
    logic ring_pme_n;
    logic spk_val;
    logic spk_oe_n;
    logic video_hiz;
  } rcc_regs_s;

  rcc_regs_s st_q;
  rcc_regs_s st_d;

  logic host_exp_w;
  logic cba_exp_w;
  logic cbb_exp_w;
  logic acc_valid;
  logic acc_mapped;
  logic [7:0] acc_idx;
  logic rd_retry;
  logic rd_card;
  logic wr_route;
  logic wr_aux;
  logic wr_retry;
  logic wr_card;
  logic wr_istat;
  logic wr_imask;
  logic [rcc_pkg::INT_W-1:0] ev;
  logic [7:0] retry_rd;
  logic [7:0] card_rd;
  logic audio_src;
  logic [1:0] t0_pick;
  logic [1:0] t1_pick;

  // Returns {output enable low-active, level} for one multifunction terminal.
  function automatic logic [1:0] term_pick(
    input logic [3:0] code,
    input logic gpo,
    input logic alt,
    input logic [15:0] irq,
    input logic vstat,
    input logic vsel,
    input logic audio,
    input logic led,
    input logic event_in
  );
    logic [1:0] r;
    r = 2'h0;
    unique case (rcc_pkg::rcc_func_e'(code))
      rcc_pkg::FN_GP_IN: r = {1'b1, 1'b0};
      rcc_pkg::FN_GP_OUT: r = {1'b0, gpo};
      rcc_pkg::FN_ALT2: r = {1'b0, alt};
      rcc_pkg::FN_IRQ3: r = {1'b0, irq[3]};
      rcc_pkg::FN_IRQ4: r = {1'b0, irq[4]};
      rcc_pkg::FN_IRQ5: r = {1'b0, irq[5]};
      rcc_pkg::FN_VID_STAT: r = {1'b0, vstat};
      rcc_pkg::FN_VID_SEL: r = {1'b0, vsel};
      rcc_pkg::FN_AUDIO: r = {1'b0, audio};
      rcc_pkg::FN_IRQ9: r = {1'b0, irq[9]};
      rcc_pkg::FN_IRQ10: r = {1'b0, irq[10]};
      rcc_pkg::FN_IRQ11: r = {1'b0, irq[11]};
      rcc_pkg::FN_LED: r = {1'b0, led};
      rcc_pkg::FN_IRQ13: r = {1'b0, irq[13]};
      rcc_pkg::FN_EVENT: r = {1'b0, event_in};
      rcc_pkg::FN_IRQ15: r = {1'b0, irq[15]};
    endcase
    return r;
  endfunction : term_pick

  rcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_host_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_q.host_en),
    .retry_start_i(host_retry_start_i),
    .master_back_i(host_master_back_i),
    .expired_o(host_exp_w)
  );

  rcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_a_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_q.card_en),
    .retry_start_i(card_a_retry_start_i),
    .master_back_i(card_a_master_back_i),
    .expired_o(cba_exp_w)
  );

  rcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_b_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_q.card_en),
    .retry_start_i(card_b_retry_start_i),
    .master_back_i(card_b_master_back_i),
    .expired_o(cbb_exp_w)
  );

  assign acc_valid = hsel_i && hready_i && htrans_i[1];
  assign acc_mapped = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0);
  assign acc_idx = haddr_i[9:2];
  assign rd_retry = acc_valid && !hwrite_i && acc_mapped && acc_idx == rcc_pkg::IDX_RETRY;
  assign rd_card = acc_valid && !hwrite_i && acc_mapped && acc_idx == rcc_pkg::IDX_CARD;
  assign wr_route = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_ROUTE;
  assign wr_aux = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_AUX;
  assign wr_retry = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_RETRY;
  assign wr_card = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_CARD;
  assign wr_istat = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_ISTAT;
  assign wr_imask = st_q.wr_pend && st_q.wr_idx == rcc_pkg::IDX_IMASK;

  always_comb begin
    st_d = st_q;
    ev = '0;
    ev[rcc_pkg::IS_HOST] = host_exp_w;
    ev[rcc_pkg::IS_CBA] = cba_exp_w;
    ev[rcc_pkg::IS_CBB] = cbb_exp_w;
    ev[rcc_pkg::IS_FUNC] = card_func_irq_i;

    // Register writes land in the data phase; hardware sets are OR-ed in after the clears.
    if (wr_route) begin
      st_d.route = hwdata_i;
    end
    if (wr_aux) begin
      st_d.aux = hwdata_i[7:0];
    end
    if (wr_retry) begin
      st_d.host_en = hwdata_i[rcc_pkg::RS_HOST_EN];
      st_d.card_en = hwdata_i[rcc_pkg::RS_CARD_EN];
      st_d.host_exp = st_q.host_exp && !hwdata_i[rcc_pkg::RS_HOST_EXP];
      st_d.cba_exp = st_q.cba_exp && !hwdata_i[rcc_pkg::RS_CBA_EXP];
      st_d.cbb_exp = st_q.cbb_exp && !hwdata_i[rcc_pkg::RS_CBB_EXP];
    end
    if (wr_card) begin
      st_d.ring_en = hwdata_i[rcc_pkg::CC_RING_EN];
      st_d.video_en = hwdata_i[rcc_pkg::CC_VIDEO];
      st_d.rsvd5 = hwdata_i[rcc_pkg::CC_RSVD5];
      st_d.audio_mux = hwdata_i[rcc_pkg::CC_AUDIO_MUX];
      st_d.spk_en = hwdata_i[rcc_pkg::CC_SPK_EN];
      st_d.func_flag = st_q.func_flag && !hwdata_i[rcc_pkg::CC_FUNC_IRQ];
    end
    if (wr_istat) begin
      st_d.istat = st_q.istat & ~hwdata_i[rcc_pkg::INT_W-1:0];
    end
    if (wr_imask) begin
      st_d.imask = hwdata_i[rcc_pkg::INT_W-1:0];
    end
    st_d.host_exp = st_d.host_exp || host_exp_w;
    st_d.cba_exp = st_d.cba_exp || cba_exp_w;
    st_d.cbb_exp = st_d.cbb_exp || cbb_exp_w;
    st_d.func_flag = st_d.func_flag || card_func_irq_i;
    st_d.istat = st_d.istat | ev;
    st_d.irq = |(st_d.istat & st_d.imask);

    // Address phase capture; any word-aligned mapped address is written, whatever the transfer size.
    st_d.wr_pend = acc_valid && hwrite_i && acc_mapped;
    st_d.wr_idx = acc_idx;
    st_d.ready = 1'b1;

    retry_rd = 8'h00;
    retry_rd[rcc_pkg::RS_HOST_EN] = st_d.host_en;
    retry_rd[rcc_pkg::RS_CARD_EN] = st_d.card_en;
    retry_rd[rcc_pkg::RS_CBB_EXP] = st_d.cbb_exp;
    retry_rd[rcc_pkg::RS_CBA_EXP] = st_d.cba_exp;
    retry_rd[rcc_pkg::RS_HOST_EXP] = st_d.host_exp;
    card_rd = 8'h00;
    card_rd[rcc_pkg::CC_RING_EN] = st_d.ring_en;
    card_rd[rcc_pkg::CC_VIDEO] = st_d.video_en;
    card_rd[rcc_pkg::CC_RSVD5] = st_d.rsvd5;
    card_rd[rcc_pkg::CC_AUDIO_MUX] = st_d.audio_mux;
    card_rd[rcc_pkg::CC_SPK_EN] = st_d.spk_en;
    card_rd[rcc_pkg::CC_FUNC_IRQ] = st_d.func_flag;

    // Reads return the value after any write completing in the same cycle, so a
    // read straight after a write never sees stale data and needs no wait state.
    st_d.rdata = 32'h0000_0000;
    if (acc_valid && !hwrite_i && acc_mapped) begin
      unique case (acc_idx)
        rcc_pkg::IDX_ROUTE: st_d.rdata = st_d.route;
        rcc_pkg::IDX_AUX: st_d.rdata = {21'h000000,
                                        multi_terminal_2_i, multi_terminal_1_i,
                                        multi_terminal_0_i, st_d.aux};
        rcc_pkg::IDX_RETRY: st_d.rdata = {24'h000000, retry_rd & rcc_pkg::RETRY_RD_MASK};
        rcc_pkg::IDX_CARD: st_d.rdata = {24'h000000, card_rd};
        rcc_pkg::IDX_ISTAT: st_d.rdata = {28'h0000000, st_d.istat};
        rcc_pkg::IDX_IMASK: st_d.rdata = {28'h0000000, st_d.imask};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    // Terminal drive, taken from the register values that hold after this edge.
    audio_src = st_d.audio_mux ? card_audio_i : audio_pwm_i;
    t0_pick = term_pick(st_d.route[rcc_pkg::RT_T0_LSB +: rcc_pkg::RT_FIELD_W],
                        st_d.aux[rcc_pkg::AUX_GPO_LSB], inta_n_i, irq_lines_i,
                        video_status_i, video_select_i, audio_src,
                        socket_activity_led_i, general_event_i);
    t1_pick = term_pick(st_d.route[rcc_pkg::RT_T1_LSB +: rcc_pkg::RT_FIELD_W],
                        st_d.aux[rcc_pkg::AUX_GPO_LSB + 1], serial_data_i, irq_lines_i,
                        video_status_i, video_select_i, audio_src,
                        socket_activity_led_i, general_event_i);
    st_d.term_oe_n[0] = t0_pick[1];
    st_d.term_val[0] = t0_pick[0];
    st_d.term_oe_n[1] = t1_pick[1];
    st_d.term_val[1] = t1_pick[0];

    // Terminal 2 carries only input, output, ring and event; other codes leave it floating.
    st_d.term_oe_n[2] = 1'b1;
    st_d.term_val[2] = 1'b0;
    unique case (st_d.route[rcc_pkg::RT_T2_LSB +: rcc_pkg::RT_FIELD_W])
      rcc_pkg::T2_RING_CODE: begin
        st_d.term_oe_n[2] = 1'b0;
        st_d.term_val[2] = st_d.ring_en ? ring_indicate_n_i : 1'b1;
      end
      rcc_pkg::T2_EVENT_CODE: begin
        st_d.term_oe_n[2] = 1'b0;
        st_d.term_val[2] = general_event_i;
      end
      rcc_pkg::FN_GP_OUT: begin
        st_d.term_oe_n[2] = 1'b0;
        st_d.term_val[2] = st_d.aux[rcc_pkg::AUX_GPO_LSB + 2];
      end
      default: begin
        st_d.term_oe_n[2] = 1'b1;
      end
    endcase

    st_d.ring_pme_n = (st_d.ring_en && !st_d.aux[rcc_pkg::AUX_RING_MUX]) ?
                      ring_indicate_n_i : pme_n_i;
    st_d.spk_oe_n = !st_d.spk_en;
    st_d.spk_val = st_d.spk_en ? card_speaker_i : 1'b0;
    st_d.video_hiz = st_d.video_en;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.route <= rcc_pkg::ROUTE_RESET;
      st_q.aux <= rcc_pkg::AUX_RESET;
      st_q.host_en <= rcc_pkg::RETRY_RESET[rcc_pkg::RS_HOST_EN];
      st_q.card_en <= rcc_pkg::RETRY_RESET[rcc_pkg::RS_CARD_EN];
      st_q.rsvd5 <= rcc_pkg::CARD_RESET[rcc_pkg::CC_RSVD5];
      st_q.ready <= 1'b1;
      st_q.term_oe_n <= 3'h7;
      st_q.ring_pme_n <= 1'b1;
      st_q.spk_oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata_o = st_q.rdata;
  assign hreadyout_o = st_q.ready;
  assign hresp_o = 1'b0;
  assign irq_o = st_q.irq;
  assign multi_terminal_0_o = st_q.term_val[0];
  assign multi_terminal_0_oe_n_o = st_q.term_oe_n[0];
  assign multi_terminal_1_o = st_q.term_val[1];
  assign multi_terminal_1_oe_n_o = st_q.term_oe_n[1];
  assign multi_terminal_2_o = st_q.term_val[2];
  assign multi_terminal_2_oe_n_o = st_q.term_oe_n[2];
  assign ring_pme_n_o = st_q.ring_pme_n;
  assign speaker_out_terminal_o = st_q.spk_val;
  assign speaker_out_terminal_oe_n_o = st_q.spk_oe_n;
  assign video_hiz_o = st_q.video_hiz;

  a_host_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    host_exp_w |=> st_q.host_exp) else $error("host retry expiry not flagged");

  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (card_func_irq_i && wr_card && hwdata_i[rcc_pkg::CC_FUNC_IRQ]) |=> st_q.func_flag)
    else $error("clear won over a same-cycle card interrupt");

  a_retry_reserved_bits_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_retry |=> ((hrdata_o[7:0] & ~rcc_pkg::RETRY_RD_MASK) == 8'h00))
    else $error("retry status reserved bits read nonzero");

  a_card_reserved_bits_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_card |=> (!hrdata_o[rcc_pkg::CC_RSVD4] && !hrdata_o[rcc_pkg::CC_RSVD3]))
    else $error("card control bits 4 and 3 read nonzero");

  a_ring_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.route[rcc_pkg::RT_T2_LSB +: rcc_pkg::RT_FIELD_W] == rcc_pkg::T2_RING_CODE
     && !st_q.ring_en) |-> (multi_terminal_2_o && !multi_terminal_2_oe_n_o))
    else $error("ring indicate routed while disabled");

  a_ring_pme_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.ring_en && !st_q.aux[rcc_pkg::AUX_RING_MUX]) |-> ring_pme_n_o == $past(ring_indicate_n_i))
    else $error("ring indicate missing on ring/PME terminal");

  a_video_float: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_card |=> (video_hiz_o == $past(hwdata_i[rcc_pkg::CC_VIDEO])))
    else $error("video float does not follow enable");

  a_speaker_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st_q.spk_en |-> speaker_out_terminal_oe_n_o) else $error("speaker driven while off");

  a_card_audio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.route[rcc_pkg::RT_T0_LSB +: rcc_pkg::RT_FIELD_W] == rcc_pkg::FN_AUDIO
     && st_q.audio_mux) |-> multi_terminal_0_o == $past(card_audio_i))
    else $error("card audio not on terminal 0");

  a_func_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    card_func_irq_i |=> (st_q.func_flag && st_q.istat[rcc_pkg::IS_FUNC]))
    else $error("card interrupt not flagged");
endmodule : rcc_regs
`default_nettype wire

/* File: verif/rcc_regs_tb_top.sv */
// Self-checking testbench of the retry and card control register slice.
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (a), (e)); end end
module rcc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // A short retry limit keeps the expiry scenarios within a few dozen cycles.
  localparam int unsigned LIM = 16;
  logic clk = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] src = 32'h0;
  logic [2:0] st = 3'h0;
  logic [2:0] bk = 3'h0;
  logic fi = 1'b0;
  logic [31:0] seed = 32'h107FC;
  logic [31:0] r;
  logic [31:0] rt;
  logic [31:0] aux;
  logic [7:0] cc;
  logic [7:0] en;
  int n;
  int err_count = 0;
  int n_checks = 0;
  wire logic [31:0] hrdata;
  wire logic hrdy;
  wire logic hresp;
  wire logic irq;
  wire logic [2:0] t_o;
  wire logic [2:0] t_oe;
  wire logic ring_n;
  wire logic spk_o;
  wire logic spk_oe;
  wire logic vhiz;

  always #25 clk = ~clk;

  rcc_regs #(.RETRY_LIMIT(LIM)) u_rcc_regs (
    .clk_i(clk), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .irq_o(irq),
    .host_retry_start_i(st[0]), .host_master_back_i(bk[0]),
    .card_a_retry_start_i(st[1]), .card_a_master_back_i(bk[1]),
    .card_b_retry_start_i(st[2]), .card_b_master_back_i(bk[2]),
    .card_func_irq_i(fi), .irq_lines_i(src[15:0]), .inta_n_i(src[16]),
    .serial_data_i(src[17]), .video_status_i(src[18]), .video_select_i(src[19]),
    .audio_pwm_i(src[20]), .card_audio_i(src[21]), .socket_activity_led_i(src[22]),
    .general_event_i(src[23]), .ring_indicate_n_i(src[24]), .pme_n_i(src[25]),
    .card_speaker_i(src[26]), .multi_terminal_0_i(src[27]), .multi_terminal_0_o(t_o[0]),
    .multi_terminal_0_oe_n_o(t_oe[0]), .multi_terminal_1_i(src[28]),
    .multi_terminal_1_o(t_o[1]), .multi_terminal_1_oe_n_o(t_oe[1]),
    .multi_terminal_2_i(src[29]), .multi_terminal_2_o(t_o[2]),
    .multi_terminal_2_oe_n_o(t_oe[2]), .ring_pme_n_o(ring_n),
    .speaker_out_terminal_o(spk_o), .speaker_out_terminal_oe_n_o(spk_oe),
    .video_hiz_o(vhiz));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected {oe_n, value} of terminal 0 or 1 for a routing code.
  function automatic logic [1:0] exp_term(input logic [3:0] c, input int t);
    case (c)
      4'h0: return 2'b10;
      4'h1: return {1'b0, aux[t]};
      4'h2: return {1'b0, (t == 0) ? src[16] : src[17]};
      4'h6: return {1'b0, src[18]};
      4'h7: return {1'b0, src[19]};
      4'h8: return {1'b0, cc[2] ? src[21] : src[20]};
      4'hC: return {1'b0, src[22]};
      4'hE: return {1'b0, src[23]};
      default: return {1'b0, src[c]};
    endcase
  endfunction : exp_term

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      k++;
      if (k > 20) begin
        err_count++;
        complete_run();
      end
      @(posedge clk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask : ticks

  task automatic pulse(input int t);
    st <= 3'(1 << t);
    @(posedge clk);
    st <= 3'h0;
  endtask : pulse

  initial begin
    ticks(8);
    rst_n_i <= 1'b1;
    ticks(1);
    bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
    `CHK(r, 32'hC0)
    bus(1'b0, rcc_pkg::IDX_CARD, 32'h0, r);
    `CHK(r, 32'h0)
    wr(8'hFF, 32'hFFFF_FFFF);
    bus(1'b0, 8'hFF, 32'h0, r);
    `CHK(r, 32'h0)
    wr(rcc_pkg::IDX_RETRY, 32'hFF);
    bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
    `CHK(r, 32'hC0)
    wr(rcc_pkg::IDX_IMASK, 32'hF);
    for (int i = 0; i < 32; i++) begin
      rt = {20'h0, 4'hC, ~i[3:0], i[3:0]};
      cc = 8'(xs()) & 8'hDF;
      aux = xs() & 32'h17;
      src <= xs();
      wr(rcc_pkg::IDX_ROUTE, rt);
      wr(rcc_pkg::IDX_AUX, aux);
      wr(rcc_pkg::IDX_CARD, {24'h0, cc});
      ticks(3);
      bus(1'b0, rcc_pkg::IDX_CARD, 32'h0, r);
      `CHK(r, {24'h0, cc & 8'hC6})
      bus(1'b0, rcc_pkg::IDX_ROUTE, 32'h0, r);
      `CHK(r, rt)
      bus(1'b0, rcc_pkg::IDX_AUX, 32'h0, r);
      `CHK(r, {21'h0, src[29:27], aux[7:0]})
      `CHK({t_oe[0], t_o[0] & ~t_oe[0]}, exp_term(rt[3:0], 0))
      `CHK({t_oe[1], t_o[1] & ~t_oe[1]}, exp_term(rt[7:4], 1))
      `CHK({t_oe[2], t_o[2]}, {1'b0, cc[7] ? src[24] : 1'b1})
      `CHK(ring_n, (cc[7] && !aux[4]) ? src[24] : src[25])
      `CHK({spk_oe, spk_o}, {~cc[1], cc[1] & src[26]})
      `CHK(vhiz, cc[6])
    end
    for (int t = 0; t < 3; t++) begin
      pulse(t);
      n = 1;
      while (irq !== 1'b1 && n < LIM + 10) begin
        @(posedge clk);
        n++;
      end
      `CHK(n >= LIM + 2 && n <= LIM + 4, 1'b1)
      bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
      `CHK(r, 32'hC0 | (32'h2 << (2 * t)))
      wr(rcc_pkg::IDX_RETRY, 32'hC0 | (32'h2 << (2 * t)));
      wr(rcc_pkg::IDX_ISTAT, 32'h1 << t);
      bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
      `CHK(r, 32'hC0)
      pulse(t);
      ticks(4);
      bk <= 3'(1 << t);
      ticks(1);
      bk <= 3'h0;
      ticks(LIM + 8);
      bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
      `CHK(r, 32'hC0)
      en = (t == 0) ? 8'h40 : 8'h80;
      wr(rcc_pkg::IDX_RETRY, {24'h0, en});
      pulse(t);
      ticks(LIM + 8);
      bus(1'b0, rcc_pkg::IDX_RETRY, 32'h0, r);
      `CHK(r, {24'h0, en})
      wr(rcc_pkg::IDX_RETRY, 32'hC0);
    end
    wr(rcc_pkg::IDX_IMASK, 32'h0);
    fi <= 1'b1;
    ticks(1);
    fi <= 1'b0;
    ticks(3);
    `CHK(irq, 1'b0)
    bus(1'b0, rcc_pkg::IDX_CARD, 32'h0, r);
    `CHK(r[0], 1'b1)
    wr(rcc_pkg::IDX_IMASK, 32'h8);
    ticks(2);
    `CHK(irq, 1'b1)
    fi <= 1'b1;
    wr(rcc_pkg::IDX_CARD, 32'h1);
    // The interrupt drops right after the clearing edge, so only a set that won keeps the flag.
    fi <= 1'b0;
    bus(1'b0, rcc_pkg::IDX_CARD, 32'h0, r);
    `CHK(r[0], 1'b1)
    wr(rcc_pkg::IDX_CARD, 32'h1);
    bus(1'b0, rcc_pkg::IDX_CARD, 32'h0, r);
    `CHK(r[0], 1'b0)
    wr(rcc_pkg::IDX_ISTAT, 32'h8);
    ticks(2);
    `CHK(irq, 1'b0)
    complete_run();
  end
endmodule : rcc_regs_tb_top
`undef CHK
`default_nettype wire
